// File: logic/csfr_pkg.sv
// Package for the core special-function block: register offsets, field positions,
// reset values, mode codes and the program-counter and stack geometry.
// Assumes a 9-bit data address space driven by the processor core.
package csfr_pkg;

  // Data space, program-counter and stack geometry
  localparam int unsigned CSFR_ADDR_W = 9;
  localparam int unsigned CSFR_DATA_W = 8;
  localparam int unsigned CSFR_PC_W = 13;
  localparam int unsigned CSFR_JUMP_W = 11;
  localparam int unsigned CSFR_STACK_DEPTH = 8;
  localparam int unsigned CSFR_STACK_PTR_W = 3;

  // Register offsets in data space
  localparam logic [8:0] CSFR_ADDR_INDIRECT = 9'h000;
  localparam logic [8:0] CSFR_ADDR_PC_LOW = 9'h002;
  localparam logic [8:0] CSFR_ADDR_BANK = 9'h003;
  localparam logic [8:0] CSFR_ADDR_POINTER = 9'h004;
  localparam logic [8:0] CSFR_ADDR_PC_LATCH = 9'h00A;
  localparam logic [8:0] CSFR_ADDR_EVENT_FLAGS = 9'h00C;
  localparam logic [8:0] CSFR_ADDR_RESET_CAUSE = 9'h08E;
  localparam logic [8:0] CSFR_ADDR_PIN_STEER = 9'h099;

  // Event flag positions
  localparam int unsigned CSFR_CONVERTER_DONE_BIT = 6;
  localparam int unsigned CSFR_CAPCMP_EVENT_BIT = 5;
  localparam int unsigned CSFR_COMPARATOR_CHANGE_BIT = 3;
  localparam int unsigned CSFR_PERIOD_MATCH_BIT = 1;
  localparam int unsigned CSFR_TIMER_ONE_OVERFLOW_BIT = 0;

  // Implemented flag positions, full and reduced variants
  localparam logic [7:0] CSFR_FLAGS_MASK_FULL = 8'h6B;
  localparam logic [7:0] CSFR_FLAGS_MASK_REDUCED = 8'h08;

  // Reset cause positions
  localparam int unsigned CSFR_POR_STATUS_BIT = 1;
  localparam int unsigned CSFR_BROWNOUT_STATUS_BIT = 0;

  // Pin steering positions
  localparam int unsigned CSFR_GATE_PIN_SELECT_BIT = 4;
  localparam int unsigned CSFR_PWM_SECOND_PIN_SELECT_BIT = 1;
  localparam int unsigned CSFR_PWM_FIRST_PIN_SELECT_BIT = 0;

  // Bank select position in the bank register
  localparam int unsigned CSFR_BANK_SELECT_BIT = 7;

  // Implemented bits of the upper latch
  localparam logic [7:0] CSFR_PC_LATCH_MASK = 8'h1F;

  // Reset values and interrupt vector
  localparam logic [7:0] CSFR_FLAGS_RESET = 8'h00;
  localparam logic [7:0] CSFR_PC_LATCH_RESET = 8'h00;
  localparam logic [7:0] CSFR_POINTER_RESET = 8'h00;
  localparam logic [7:0] CSFR_PIN_STEER_RESET = 8'h00;
  localparam logic [12:0] CSFR_PC_RESET = 13'h0000;
  localparam logic [12:0] CSFR_IRQ_VECTOR = 13'h0004;

  // Capture/compare module modes
  typedef enum logic [1:0] {
    CSFR_CCP_OFF,
    CSFR_CCP_CAPTURE,
    CSFR_CCP_COMPARE,
    CSFR_CCP_PWM
  } csfr_ccp_mode_e;

endpackage : csfr_pkg

// File: logic/csfr_core.sv
// Core special-function logic: event flags, reset cause, pin steering,
// program counter with upper latch, eight-level return stack, indirect access.
// Assumes the core and peripherals are synchronous to clk_i and the register
// port strobes are single-cycle and never both high.
// The reduced variant drops the converter, capture/compare, period-match and
// timer-one overflow flags and leaves every PWM pad undriven.
//
// Contract
// - Flags set regardless of interrupt enables
// - Converter-done flag sets on conversion complete
// - Capture/compare flag sets in capture/compare modes
// - Comparator change flag sets on output change
// - Period-match flag sets on timer-two match
// - Timer-one overflow flag sets on overflow
// - Unimplemented and variant flag bits read zero
// - Power-on reset clears status; software sets it
// - Brown-out reset clears status; reads zero disabled
// - Reset-cause upper six bits read zero
// - Gate select picks pin three or four
// - Second PWM select picks pin four or zero
// - First PWM select picks pin five or two
// - Thirteen-bit counter, low byte read/write
// - Every reset clears whole program counter
// - Low-byte write loads upper five latch bits
// - Call/jump takes top two bits from latch
// - Eight-entry thirteen-bit hidden return stack
// - Push on call/interrupt, pop on returns
// - Stack wraps circularly, no overflow status
// - Indirect port reads zero through itself
// - Nine-bit indirect address: bank bit, pointer
//
// The register offsets and the address-and-strobe port were left to the implementer.
module csfr_core
  import csfr_pkg::*;
#(
  parameter bit HAS_ANALOG = 1'b1
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Synchronous reset causes and brown-out enable
  input wire logic brownout_reset_i,
  input wire logic other_reset_i,
  input wire logic brownout_enable_i,
  // Register port
  input wire logic [8:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // External data memory, read data valid in the strobe cycle
  output logic [8:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_write_o,
  output logic mem_read_o,
  input wire logic [7:0] mem_rdata_i,
  // Instruction sequencer
  input wire logic step_i,
  input wire logic call_i,
  input wire logic jump_i,
  input wire logic [10:0] jump_target_i,
  input wire logic irq_branch_i,
  input wire logic return_i,
  output logic [12:0] pc_o,
  // Peripheral events
  input wire logic converter_done_i,
  input wire logic capcmp_capture_i,
  input wire logic capcmp_compare_i,
  input wire logic [1:0] capcmp_mode_i,
  input wire logic comparator_out_i,
  input wire logic period_match_i,
  input wire logic timer_one_overflow_i,
  // Pin steering
  input wire logic port_pin_3_i,
  input wire logic port_pin_4_i,
  input wire logic pwm_first_output_i,
  input wire logic pwm_second_output_i,
  output logic timer_gate_input_o,
  output logic port_pin_0_pwm_o,
  output logic port_pin_0_pwm_oe_o,
  output logic port_pin_4_pwm_o,
  output logic port_pin_4_pwm_oe_o,
  output logic port_pin_2_pwm_o,
  output logic port_pin_2_pwm_oe_o,
  output logic port_pin_5_pwm_o,
  output logic port_pin_5_pwm_oe_o
);

  // All state of the block; the stack and its pointer are hidden from software
  // and nothing reports an overflow or underflow
  typedef struct packed {
    logic [12:0] pc;
    logic [7:0] pc_upper_latch;
    logic [7:0] pointer;
    logic bank_select;
    logic [7:0][12:0] stack;
    logic [2:0] stack_ptr;
    logic [7:0] flags;
    logic cmp_prev;
    logic por_status;
    logic brownout_status;
    logic gate_pin_select;
    logic pwm_second_pin_select;
    logic pwm_first_pin_select;
    logic [7:0] rdata;
    logic gate;
    logic [3:0] pwm_pins;
    logic [3:0] pwm_oes;
  } csfr_state_s;

  // Implemented flag positions of this variant
  localparam logic [7:0] FLAGS_MASK = HAS_ANALOG ? CSFR_FLAGS_MASK_FULL : CSFR_FLAGS_MASK_REDUCED;

  csfr_state_s state;
  csfr_state_s next_state;

  // Effective data address of an access, redirected through the pointer
  // The ninth address bit is the bank select, so both banks are reachable
  function automatic logic [8:0] csfr_resolve(input logic [8:0] addr, input logic bank, input logic [7:0] ptr);
    if (addr == CSFR_ADDR_INDIRECT) begin
      return {bank, ptr};
    end
    return addr;
  endfunction

  // True when an access lands on the indirect port through itself
  // Such an access must neither change a register nor reach the memory
  function automatic logic csfr_self_indirect(input logic [8:0] addr, input logic bank, input logic [7:0] ptr);
    return (addr == CSFR_ADDR_INDIRECT) && ({bank, ptr} == CSFR_ADDR_INDIRECT);
  endfunction

  // True when the effective address belongs to this block
  // Local registers are matched on all nine bits; everything else goes out
  function automatic logic csfr_local(input logic [8:0] eff);
    case (eff)
      CSFR_ADDR_INDIRECT, CSFR_ADDR_PC_LOW, CSFR_ADDR_BANK, CSFR_ADDR_POINTER,
      CSFR_ADDR_PC_LATCH, CSFR_ADDR_EVENT_FLAGS, CSFR_ADDR_RESET_CAUSE,
      CSFR_ADDR_PIN_STEER: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  logic [8:0] eff_addr;
  logic self_ind;
  logic sw_write;
  logic is_local;
  logic [7:0] event_set;
  logic [7:0] local_rdata;
  logic [12:0] pc_plus_one;
  logic [2:0] ptr_down;
  csfr_ccp_mode_e ccp_mode;

  // Address resolution for the current access
  assign eff_addr = csfr_resolve(reg_addr_i, state.bank_select, state.pointer);
  assign self_ind = csfr_self_indirect(reg_addr_i, state.bank_select, state.pointer);
  assign is_local = csfr_local(eff_addr);
  assign sw_write = reg_write_i && !self_ind;
  assign pc_plus_one = state.pc + 13'h0001;
  assign ptr_down = state.stack_ptr - 3'h1;
  assign ccp_mode = csfr_ccp_mode_e'(capcmp_mode_i);

  // Hardware flag set terms, independent of any interrupt enable;
  // a strobe in PWM or off mode never raises the capture/compare flag,
  // and the comparator term is the level against last cycle's sample
  always_comb begin
    event_set = 8'h00;
    event_set[CSFR_CONVERTER_DONE_BIT] = converter_done_i;
    case (ccp_mode)
      CSFR_CCP_CAPTURE: event_set[CSFR_CAPCMP_EVENT_BIT] = capcmp_capture_i;
      CSFR_CCP_COMPARE: event_set[CSFR_CAPCMP_EVENT_BIT] = capcmp_compare_i;
      default: event_set[CSFR_CAPCMP_EVENT_BIT] = 1'b0;
    endcase
    event_set[CSFR_COMPARATOR_CHANGE_BIT] = comparator_out_i ^ state.cmp_prev;
    event_set[CSFR_PERIOD_MATCH_BIT] = period_match_i;
    event_set[CSFR_TIMER_ONE_OVERFLOW_BIT] = timer_one_overflow_i;
  end

  // Read view of the local registers
  // Unimplemented positions stay at the zero default
  always_comb begin
    local_rdata = 8'h00;
    case (eff_addr)
      CSFR_ADDR_PC_LOW: local_rdata = state.pc[7:0];
      CSFR_ADDR_BANK: local_rdata[CSFR_BANK_SELECT_BIT] = state.bank_select;
      CSFR_ADDR_POINTER: local_rdata = state.pointer;
      CSFR_ADDR_PC_LATCH: local_rdata = state.pc_upper_latch & CSFR_PC_LATCH_MASK;
      CSFR_ADDR_EVENT_FLAGS: local_rdata = state.flags & FLAGS_MASK;
      CSFR_ADDR_RESET_CAUSE: begin
        local_rdata[CSFR_POR_STATUS_BIT] = state.por_status;
        local_rdata[CSFR_BROWNOUT_STATUS_BIT] = state.brownout_status & brownout_enable_i;
      end
      CSFR_ADDR_PIN_STEER: begin
        local_rdata[CSFR_GATE_PIN_SELECT_BIT] = state.gate_pin_select;
        local_rdata[CSFR_PWM_SECOND_PIN_SELECT_BIT] = state.pwm_second_pin_select;
        local_rdata[CSFR_PWM_FIRST_PIN_SELECT_BIT] = state.pwm_first_pin_select;
      end
      default: local_rdata = 8'h00;
    endcase
  end

  // External memory strobes for non-local effective addresses
  // A self-indirect access counts as local, so it never strobes the memory
  assign mem_addr_o = eff_addr;
  assign mem_wdata_o = reg_wdata_i;
  assign mem_write_o = reg_write_i && !is_local;
  assign mem_read_o = reg_read_i && !is_local;

  // Next-state logic
  always_comb begin
    logic [7:0] flag_base;
    flag_base = state.flags;
    next_state = state;
    next_state.cmp_prev = comparator_out_i;

    // Read data, standing for one cycle only so that a stale answer is
    // never taken for a fresh one; a self-indirect read answers zero,
    // and a non-local read passes the memory's same-cycle answer on
    next_state.rdata = 8'h00;
    if (reg_read_i) begin
      if (self_ind) begin
        next_state.rdata = 8'h00;
      end else if (is_local) begin
        next_state.rdata = local_rdata;
      end else begin
        next_state.rdata = mem_rdata_i;
      end
    end

    // Software writes to local registers; self-indirect writes do nothing.
    // The upper latch keeps only its five implemented bits, and the flag
    // write is held back so that events can be merged in afterwards
    if (sw_write && is_local) begin
      case (eff_addr)
        CSFR_ADDR_BANK: next_state.bank_select = reg_wdata_i[CSFR_BANK_SELECT_BIT];
        CSFR_ADDR_POINTER: next_state.pointer = reg_wdata_i;
        CSFR_ADDR_PC_LATCH: next_state.pc_upper_latch = reg_wdata_i & CSFR_PC_LATCH_MASK;
        CSFR_ADDR_EVENT_FLAGS: flag_base = reg_wdata_i;
        CSFR_ADDR_RESET_CAUSE: begin
          next_state.por_status = reg_wdata_i[CSFR_POR_STATUS_BIT];
          next_state.brownout_status = reg_wdata_i[CSFR_BROWNOUT_STATUS_BIT];
        end
        CSFR_ADDR_PIN_STEER: begin
          next_state.gate_pin_select = reg_wdata_i[CSFR_GATE_PIN_SELECT_BIT];
          next_state.pwm_second_pin_select = reg_wdata_i[CSFR_PWM_SECOND_PIN_SELECT_BIT];
          next_state.pwm_first_pin_select = reg_wdata_i[CSFR_PWM_FIRST_PIN_SELECT_BIT];
        end
        default: begin
        end
      endcase
    end

    // Flags: event set wins over a software clear in the same cycle, so an
    // event that meets a clear is never lost; unimplemented positions are
    // masked so that writing ones there cannot make them read back
    next_state.flags = (flag_base | event_set) & FLAGS_MASK;

    // Program counter and stack; a low-byte write has top priority, and
    // lower-priority sequencer requests of the same cycle are dropped.
    // The pointer wraps modulo eight, so a ninth push overwrites the oldest
    // entry; pushes and pops leave the upper latch alone
    if (sw_write && eff_addr == CSFR_ADDR_PC_LOW) begin
      next_state.pc = {state.pc_upper_latch[4:0], reg_wdata_i};
    end else if (call_i) begin
      next_state.stack[state.stack_ptr] = pc_plus_one;
      next_state.stack_ptr = state.stack_ptr + 3'h1;
      next_state.pc = {state.pc_upper_latch[4:3], jump_target_i};
    end else if (jump_i) begin
      next_state.pc = {state.pc_upper_latch[4:3], jump_target_i};
    end else if (irq_branch_i) begin
      next_state.stack[state.stack_ptr] = state.pc;
      next_state.stack_ptr = state.stack_ptr + 3'h1;
      next_state.pc = CSFR_IRQ_VECTOR;
    end else if (return_i) begin
      next_state.pc = state.stack[ptr_down];
      next_state.stack_ptr = ptr_down;
    end else if (step_i) begin
      next_state.pc = pc_plus_one;
    end

    // Pin steering, registered toward the pads; the gate input and the
    // PWM levels therefore reach their destinations one cycle late
    next_state.gate = state.gate_pin_select ? port_pin_3_i : port_pin_4_i;
    next_state.pwm_pins = 4'h0;
    next_state.pwm_oes = 4'h0;
    if (HAS_ANALOG) begin
      if (state.pwm_second_pin_select) begin
        next_state.pwm_pins[1] = pwm_second_output_i;
        next_state.pwm_oes[1] = 1'b1;
      end else begin
        next_state.pwm_pins[0] = pwm_second_output_i;
        next_state.pwm_oes[0] = 1'b1;
      end
      if (state.pwm_first_pin_select) begin
        next_state.pwm_pins[3] = pwm_first_output_i;
        next_state.pwm_oes[3] = 1'b1;
      end else begin
        next_state.pwm_pins[2] = pwm_first_output_i;
        next_state.pwm_oes[2] = 1'b1;
      end
    end

    // Synchronous reset causes clear the counter; brown-out clears its status bit.
    // These come last so that they override the counter load of any sequencer
    // request or low-byte counter write of the same cycle, but not a stack push or pop
    if (brownout_reset_i || other_reset_i) begin
      next_state.pc = CSFR_PC_RESET;
      next_state.rdata = 8'h00;
    end
    if (brownout_reset_i) begin
      next_state.brownout_status = 1'b0;
    end
  end

  // State register; power-on reset clears counter and power-on status.
  // The brown-out status starts at zero too, so software sets both bits
  // after power-up to tell later reset causes apart
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= '0;
      state.pc <= CSFR_PC_RESET;
      state.pc_upper_latch <= CSFR_PC_LATCH_RESET;
      state.pointer <= CSFR_POINTER_RESET;
      state.flags <= CSFR_FLAGS_RESET;
      state.por_status <= 1'b0;
      state.brownout_status <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  // None of these depends combinationally on an input
  assign reg_rdata_o = state.rdata;
  assign pc_o = state.pc;
  assign timer_gate_input_o = state.gate;
  assign port_pin_0_pwm_o = state.pwm_pins[0];
  assign port_pin_4_pwm_o = state.pwm_pins[1];
  assign port_pin_2_pwm_o = state.pwm_pins[2];
  assign port_pin_5_pwm_o = state.pwm_pins[3];
  assign port_pin_0_pwm_oe_o = state.pwm_oes[0];
  assign port_pin_4_pwm_oe_o = state.pwm_oes[1];
  assign port_pin_2_pwm_oe_o = state.pwm_oes[2];
  assign port_pin_5_pwm_oe_o = state.pwm_oes[3];

endmodule : csfr_core

// File: sim/csfr_core_properties.sv
// Port checker for csfr_core: flags, reset cause, program counter, steering.
// Assumes it is bound to csfr_core and sees only its ports.
module csfr_core_properties
  import csfr_pkg::*;
(
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic brownout_reset_i,
  input wire logic other_reset_i,
  // Register port
  input wire logic [8:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [8:0] mem_addr_o,
  // Sequencer and pins
  input wire logic call_i,
  input wire logic jump_i,
  input wire logic [10:0] jump_target_i,
  input wire logic irq_branch_i,
  input wire logic [12:0] pc_o,
  input wire logic port_pin_3_i,
  input wire logic port_pin_4_i,
  input wire logic timer_gate_input_o
);
  typedef struct packed {logic [4:0] lat; logic bnk; logic [7:0] ptr; logic gsel;} csfr_chk_s;
  csfr_chk_s s;
  csfr_chk_s next_s;
  wire logic rst_any = brownout_reset_i || other_reset_i;
  wire logic pcl_wr = reg_write_i && reg_addr_i == CSFR_ADDR_PC_LOW;
  wire logic [12:0] pcl_val = {s.lat, reg_wdata_i};
  wire logic [12:0] jmp_val = {s.lat[4:3], jump_target_i};
  wire logic gate_src = s.gsel ? port_pin_3_i : port_pin_4_i;
  // Shadow of latch, pointer, bank and gate select
  always_comb begin
    next_s = s;
    if (reg_write_i && reg_addr_i == CSFR_ADDR_PC_LATCH) next_s.lat = reg_wdata_i[4:0];
    if (reg_write_i && reg_addr_i == CSFR_ADDR_POINTER) next_s.ptr = reg_wdata_i;
    if (reg_write_i && reg_addr_i == CSFR_ADDR_BANK) next_s.bnk = reg_wdata_i[7];
    if (reg_write_i && reg_addr_i == CSFR_ADDR_PIN_STEER) next_s.gsel = reg_wdata_i[4];
  end
  // Shadow register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) s <= '0;
    else s <= next_s;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  flag_pad_zero_a: assert property (reg_read_i && reg_addr_i == CSFR_ADDR_EVENT_FLAGS |=>
    (reg_rdata_o & 8'h94) == 8'h00) else $error("flag pad bits set");
  cause_pad_zero_a: assert property (reg_read_i && reg_addr_i == CSFR_ADDR_RESET_CAUSE |=>
    reg_rdata_o[7:2] == 6'h00) else $error("cause pad bits set");
  pc_clear_a: assert property (rst_any |=> pc_o == CSFR_PC_RESET) else $error("pc not cleared");
  pcl_load_a: assert property (pcl_wr && !rst_any |=> pc_o == $past(pcl_val))
    else $error("pc low write load wrong");
  jump_load_a: assert property ((call_i || jump_i) && !pcl_wr && !rst_any |=> pc_o == $past(jmp_val))
    else $error("call or jump load wrong");
  irq_vector_a: assert property (irq_branch_i && !call_i && !jump_i && !pcl_wr && !rst_any |=>
    pc_o == CSFR_IRQ_VECTOR) else $error("irq vector wrong");
  gate_route_a: assert property (!$past(rst_i) |-> timer_gate_input_o == $past(gate_src))
    else $error("gate routing wrong");
  ind_addr_a: assert property ((reg_read_i || reg_write_i) && reg_addr_i == CSFR_ADDR_INDIRECT |->
    mem_addr_o == {s.bnk, s.ptr}) else $error("indirect address wrong");
  bor_clear_a: assert property (brownout_reset_i ##1 (reg_read_i && reg_addr_i == CSFR_ADDR_RESET_CAUSE) |=>
    !reg_rdata_o[0]) else $error("brownout status not cleared");
  // Main scenarios
  call_seen_c: cover property (call_i);
  irq_seen_c: cover property (irq_branch_i);
  bor_seen_c: cover property (brownout_reset_i);
endmodule // csfr_core_properties

bind csfr_core csfr_core_properties i_csfr_core_properties (.clk_i, .rst_i, .brownout_reset_i, .other_reset_i,
  .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .mem_addr_o, .call_i, .jump_i,
  .jump_target_i, .irq_branch_i, .pc_o, .port_pin_3_i, .port_pin_4_i, .timer_gate_input_o);

// File: sim/csfr_mem_model.sv
// Data memory behind the indirect port, answering in the strobe cycle.
// Assumes one clock shared with the core.
module csfr_mem_model (
  // Clock
  input wire logic clk_i,
  // Memory port
  input wire logic [8:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic mem_write_i,
  input wire logic mem_read_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [0:511];
  logic [7:0] junk = 8'hA5;
  // Store at the effective address; junk changes every cycle
  always @(posedge clk_i) begin
    junk <= junk + 8'h3B;
    if (mem_write_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
  end
  // Answer at once, junk when not read
  assign mem_rdata_o = mem_read_i ? mem[mem_addr_i] : junk;
endmodule // csfr_mem_model

// File: sim/tb.sv
// Self-checking bench for csfr_core with a data memory partner.
// Assumes the package constants for offsets and vectors.
module tb
  import csfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = '0, rst = 1'h1, bor = '0, oth = '0, bor_en = 1'h1;
  logic [8:0] addr = '0, maddr;
  logic [7:0] wdata = '0, rdata, mwdata, mrdata;
  logic wr = '0, rd = '0, mwr, mrd, gate;
  logic call = '0, jump = '0, irq = '0, ret = '0, step = '0;
  logic [10:0] tgt = '0;
  logic [12:0] pc;
  logic [4:0] ev = '0;
  logic [1:0] mode = '0;
  logic cmp = '0, p3 = '0, p4 = '0, pa = '0, pb = '0;
  logic o0, oe0, o4, oe4, o2, oe2, o5, oe5;
  logic [4:0] evp [7] = '{5'h10, 5'h08, 5'h04, 5'h0C, 5'h02, 5'h01, 5'h00};
  int modes [7] = '{1, 1, 2, 3, 0, 0, 0};
  int expf [7] = '{'h40, 'h20, 'h20, 'h00, 'h02, 'h01, 'h08};
  int pc_m, lat_m, sp_m, error_cnt, checks_done;
  int stk [8];
  csfr_core i_csfr_core (.clk_i(clk), .rst_i(rst), .brownout_reset_i(bor), .other_reset_i(oth),
    .brownout_enable_i(bor_en), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
    .reg_rdata_o(rdata), .mem_addr_o(maddr), .mem_wdata_o(mwdata), .mem_write_o(mwr), .mem_read_o(mrd),
    .mem_rdata_i(mrdata), .step_i(step), .call_i(call), .jump_i(jump), .jump_target_i(tgt),
    .irq_branch_i(irq), .return_i(ret), .pc_o(pc), .converter_done_i(ev[4]), .capcmp_capture_i(ev[3]),
    .capcmp_compare_i(ev[2]), .capcmp_mode_i(mode), .comparator_out_i(cmp), .period_match_i(ev[1]),
    .timer_one_overflow_i(ev[0]), .port_pin_3_i(p3), .port_pin_4_i(p4), .pwm_first_output_i(pa),
    .pwm_second_output_i(pb), .timer_gate_input_o(gate), .port_pin_0_pwm_o(o0), .port_pin_0_pwm_oe_o(oe0),
    .port_pin_4_pwm_o(o4), .port_pin_4_pwm_oe_o(oe4), .port_pin_2_pwm_o(o2), .port_pin_2_pwm_oe_o(oe2),
    .port_pin_5_pwm_o(o5), .port_pin_5_pwm_oe_o(oe5));
  csfr_mem_model i_csfr_mem_model (.clk_i(clk), .mem_addr_i(maddr), .mem_wdata_i(mwdata),
    .mem_write_i(mwr), .mem_read_i(mrd), .mem_rdata_o(mrdata));
  // Clock
  always #2.5 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle register write
  task automatic wrt(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= '0;
  endtask
  // One-cycle read, answer taken in the next cycle
  task automatic rdc(input logic [8:0] a, input logic [7:0] e, input string w);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= '0;
    @(negedge clk);
    chk(rdata, e, w);
  endtask
  // Sequencer op: 0 call, 1 jump, 2 irq, 3 return, 4 step
  task automatic seq(input int k, input logic [10:0] t);
    @(posedge clk);
    tgt <= t;
    {call, jump, irq, ret, step} <= 5'h10 >> k;
    @(posedge clk);
    {call, jump, irq, ret, step} <= '0;
    if (k == 0 || k == 2) begin
      stk[sp_m] = (k == 0) ? (pc_m + 1) % 8192 : pc_m;
      sp_m = (sp_m + 1) % 8;
    end
    if (k == 3) begin
      sp_m = (sp_m + 7) % 8;
      pc_m = stk[sp_m];
    end
    else if (k == 2) pc_m = 4;
    else if (k == 4) pc_m = (pc_m + 1) % 8192;
    else pc_m = (lat_m / 8 % 4) * 2048 + t;
    @(negedge clk);
    chk(pc, pc_m, "pc");
  endtask
  // Verdict
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end
    else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report;
  end
  // Main sequence
  initial begin
    logic [7:0] sv;
    void'($urandom(10));
    repeat (5) @(posedge clk);
    rst <= '0;
    @(negedge clk);
    chk(pc, 0, "pc reset");
    rdc(CSFR_ADDR_RESET_CAUSE, 8'h00, "cause reset");
    rdc(CSFR_ADDR_PIN_STEER, 8'h00, "steer reset");
    lat_m = 16 | ($urandom % 16);
    wrt(CSFR_ADDR_PC_LATCH, 8'(lat_m) | 8'hE0);
    rdc(CSFR_ADDR_PC_LATCH, 8'(lat_m), "latch");
    sv = 8'($urandom);
    wrt(CSFR_ADDR_PC_LOW, sv);
    pc_m = lat_m * 256 + sv;
    @(negedge clk);
    chk(pc, pc_m, "pc write");
    rdc(CSFR_ADDR_PC_LOW, sv, "pc low");
    // Nine pushes wrap, nine pops, then mixed ops
    for (int i = 0; i < 9; i++) seq(0, 11'($urandom));
    for (int i = 0; i < 9; i++) seq(3, '0);
    for (int i = 0; i < 5; i++) seq(i, 11'($urandom));
    repeat (20) seq($urandom % 5, 11'($urandom));
    rdc(CSFR_ADDR_PC_LATCH, 8'(lat_m), "latch kept");
    // Reset causes
    wrt(CSFR_ADDR_RESET_CAUSE, 8'hFF);
    rdc(CSFR_ADDR_RESET_CAUSE, 8'h03, "cause set");
    @(posedge clk);
    bor_en <= '0;
    rdc(CSFR_ADDR_RESET_CAUSE, 8'h02, "bor off");
    @(posedge clk);
    bor_en <= 1'h1;
    bor <= 1'h1;
    @(posedge clk);
    bor <= '0;
    addr <= CSFR_ADDR_RESET_CAUSE;
    rd <= 1'h1;
    @(posedge clk);
    rd <= '0;
    @(negedge clk);
    chk(rdata, 8'h02, "bor cause");
    chk(pc, 0, "pc bor");
    pc_m = 0;
    wrt(CSFR_ADDR_RESET_CAUSE, 8'h03);
    seq(4, '0);
    @(posedge clk);
    oth <= 1'h1;
    @(posedge clk);
    oth <= '0;
    rdc(CSFR_ADDR_RESET_CAUSE, 8'h03, "oth cause");
    chk(pc, 0, "pc oth");
    // Event flags, enables never set
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      mode <= modes[i][1:0];
      @(posedge clk);
      ev <= evp[i];
      cmp <= (i == 6) ? ~cmp : cmp;
      @(posedge clk);
      ev <= '0;
      rdc(CSFR_ADDR_EVENT_FLAGS, 8'(expf[i]), "flag");
      wrt(CSFR_ADDR_EVENT_FLAGS, 8'h00);
    end
    wrt(CSFR_ADDR_EVENT_FLAGS, 8'hFF);
    rdc(CSFR_ADDR_EVENT_FLAGS, 8'h6B, "flag pad");
    // Set beats a same-cycle clear
    @(posedge clk);
    addr <= CSFR_ADDR_EVENT_FLAGS;
    wdata <= 8'h00;
    wr <= 1'h1;
    ev <= 5'h01;
    @(posedge clk);
    wr <= '0;
    ev <= '0;
    rdc(CSFR_ADDR_EVENT_FLAGS, 8'h01, "set wins");
    // Pin steering, every PWM select combination, gate select alternating
    for (int i = 0; i < 4; i++) begin
      sv = {3'($urandom), i[0], 2'($urandom), i[1], i[0] ^ i[1]};
      wrt(CSFR_ADDR_PIN_STEER, sv);
      rdc(CSFR_ADDR_PIN_STEER, sv & 8'h13, "steer");
      @(posedge clk);
      {p3, p4, pa, pb} <= 4'($urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(gate, sv[4] ? p3 : p4, "gate");
      chk({oe0, oe4, oe2, oe5}, {!sv[1], sv[1], !sv[0], sv[0]}, "pin oe");
      chk({sv[1] ? o4 : o0, sv[0] ? o5 : o2}, {pb, pa}, "pin out");
    end
    // Indirect access, then the port through itself
    wrt(CSFR_ADDR_POINTER, 8'h40 | 8'($urandom % 64));
    wrt(CSFR_ADDR_BANK, 8'h80);
    sv = 8'($urandom);
    wrt(CSFR_ADDR_INDIRECT, sv);
    rdc(CSFR_ADDR_INDIRECT, sv, "indirect");
    wrt(CSFR_ADDR_POINTER, 8'h00);
    wrt(CSFR_ADDR_BANK, 8'h00);
    wrt(CSFR_ADDR_INDIRECT, 8'h55);
    rdc(CSFR_ADDR_INDIRECT, 8'h00, "self read");
    // Power-on reset in mid-run clears the counter and both cause bits
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= '0;
    @(negedge clk);
    chk(pc, 0, "pc por");
    rdc(CSFR_ADDR_RESET_CAUSE, 8'h00, "por cause");
    final_report;
  end
endmodule // tb
